// >>> design/ascpd_pkg.sv
// Package with field positions, codes, reset values and carriers of the decoder.
package ascpd_pkg;

  // Command word layout.
  localparam int          WORD_BITS      = 16;
  localparam int          ROUTE_BIT      = 15;
  localparam int          SCAN_MSB       = 14;
  localparam int          SCAN_LSB       = 11;
  localparam int          CHAN_MSB       = 10;
  localparam int          CHAN_LSB       = 7;
  localparam int          PM_HI_BIT      = 4;
  localparam int          PM_LO_BIT      = 3;
  localparam int          SOFTWARE_CONVERT_BIT_BIT      = 1;
  localparam int          SEL_MSB        = 15;
  localparam int          SEL_LSB        = 11;
  localparam logic [4:0]  CFG_SELECT     = 5'h10;

  // Configuration field positions.
  localparam int          REFERENCE_CHOICE_BIT     = 10;
  localparam int          AVERAGING_ON_BIT      = 9;
  localparam int          NAVG_MSB       = 8;
  localparam int          NAVG_LSB       = 7;
  localparam int          NSCAN_MSB      = 6;
  localparam int          NSCAN_LSB      = 5;
  localparam int          SPM_MSB        = 3;
  localparam int          SPM_LSB        = 2;

  // Scan codes with a meaning in this block.
  localparam logic [3:0]  SCAN_ARBITRARY = 4'h9;
  localparam logic [3:0]  SCAN_NULL_LOW  = 4'ha;

  // Power field encodings.
  localparam logic [1:0]  PM_NORMAL      = 2'h0;
  localparam logic [1:0]  PM_FULL_OFF    = 2'h1;
  localparam logic [1:0]  PM_BIAS_KEEP   = 2'h2;
  localparam logic [1:0]  SPM_OFF        = 2'h0;
  localparam logic [1:0]  SPM_BIAS_KEEP  = 2'h2;

  // Reset values and counts.
  localparam logic [3:0]  SCAN_RESET     = 4'h0;
  localparam logic [3:0]  CHAN_RESET     = 4'h0;
  localparam logic [1:0]  FIELD2_RESET   = 2'h0;
  localparam logic        BIT_RESET      = 1'b0;
  localparam logic [1:0]  WAKE_DISCARD   = 2'h2;
  localparam int          SEQ_MAX        = 256;
  localparam logic [5:0]  AVG_BASE       = 6'h04;

  // Mode control contents.
  typedef struct packed {
    logic [3:0] scan;
    logic [3:0] startChannelPick;
    logic       autoPowerHi;
    logic       autoPowerLo;
    logic       softwareConvertBit;
  } ascpd_mode_t;

  // Configuration contents.
  typedef struct packed {
    logic       referenceChoice;
    logic       averagingOn;
    logic [1:0] averagingCount;
    logic [1:0] scanCount;
    logic [1:0] staticPowerField;
  } ascpd_cfg_t;

  typedef enum logic [1:0] {PWR_ON, PWR_FULL_OFF, PWR_BIAS_ONLY} ascpd_pwr_t;

  // Codes 1010 through 1111 leave the running mode alone.
  function automatic logic ascpdIsNull(input logic [3:0] scan);
    return scan >= SCAN_NULL_LOW;
  endfunction

  // Scan codes that run on the internal conversion clock.
  function automatic logic ascpdIsInternal(input logic [3:0] scan);
    return (scan == 4'h2) || (scan == 4'h3) || (scan == 4'h5) ||
           (scan == 4'h7);
  endfunction

endpackage

// >>> design/ascpd_link_rx.sv
// Serial receiver on the link clock: shifts one 16-bit word per frame.
`timescale 1ns/1ns
module ascpd_link_rx
  import ascpd_pkg::*;
(
  // Link pins.
  input  wire logic                  sclk,
  input  wire logic                  csN,
  input  wire logic                  mosi,
  // Captured word and its completion flag.
  output logic [WORD_BITS-1:0]       rxWord,
  output logic                       rxToggle
);

  logic [WORD_BITS-1:0] shift_reg;
  logic [4:0]           count_reg;

  // Chip select high clears the count, since the link clock stops between
  // frames and no edge can be relied on to end a frame.
  always_ff @(posedge sclk or posedge csN) begin
    if (csN) begin
      count_reg <= 5'h00;
    end else if (count_reg != 5'h10) begin
      count_reg <= count_reg + 5'h01;
    end
  end

  // Bits arrive MSB first; bits past the sixteenth are ignored.
  always_ff @(posedge sclk) begin
    if (count_reg != 5'h10) begin
      shift_reg <= {shift_reg[WORD_BITS-2:0], mosi};
    end
  end

  // The flag rises with the sixteenth bit and stands until the select rises.
  // It is a level that the system side synchronises, so the host must keep
  // the select low for a few system clocks after the last bit.
  always_ff @(posedge sclk or posedge csN) begin
    if (csN) begin
      rxToggle <= 1'b0;
    end else if (count_reg == 5'h0f) begin
      rxToggle <= 1'b1;
    end
  end

  // The word is copied once complete and then stays still until the next
  // complete frame, so the other domain may read it after the flag.
  always_ff @(posedge sclk) begin
    if (count_reg == 5'h0f) begin
      rxWord <= {shift_reg[WORD_BITS-2:0], mosi};
    end
  end

endmodule

// >>> design/ascpd_core.sv
// Command decoder for scan mode, channel pick, configuration and power-down.
`timescale 1ns/1ns
module ascpd_core
  import ascpd_pkg::*;
#(
  parameter int SEQ_DEPTH = SEQ_MAX
) (
  // System clock and reset.
  input  wire logic                  mclk,
  input  wire logic                  srst,
  // Serial link pins.
  input  wire logic                  sclk,
  input  wire logic                  csN,
  input  wire logic                  mosi,
  // Converter pin and core event.
  input  wire logic                  convertStartPinN,
  input  wire logic                  conversionsDone,
  // Register contents.
  output ascpd_pkg::ascpd_mode_t     modeReg,
  output ascpd_pkg::ascpd_cfg_t      cfgReg,
  // Decoded controls.
  output logic [3:0]                 startChannel,
  output logic                       arbitrarySequenceMode,
  output logic [8:0]                 sequenceDepth,
  output logic                       internalClockMode,
  output logic                       refExternalDiff,
  output logic                       negRefOnAnalogInputFifteen,
  output logic                       averagingActive,
  output logic [5:0]                 averageCount,
  output ascpd_pkg::ascpd_pwr_t      powerState,
  output logic                       discardResult,
  output logic                       commandTaken
);
  import ascpd_pkg::*;

  logic [WORD_BITS-1:0] rxWord;
  logic                 rxToggle;
  logic                 csSync1_reg, csSync2_reg, csPrev_reg;
  logic                 cnvSync1_reg, cnvSync2_reg, cnvPrev_reg;
  logic                 togSync1_reg, togSync2_reg, togSeen_reg;
  logic [WORD_BITS-1:0] heldWord_reg;
  logic                 pending_reg;
  logic                 autoDown_reg;
  logic [1:0]           discard_reg;
  ascpd_mode_t          mode_reg;
  ascpd_cfg_t           cfg_reg;
  ascpd_pwr_t           pwr_next;
  ascpd_pwr_t           pwr_reg;
  logic                 taken_reg;

  logic                 csRise, csFall, cnvFall, wordArrive;
  logic                 frameValid, modeWord, cfgWord, nullWord;
  logic                 autoOn, downEvent, wakeEvent, convEnd;
  logic [WORD_BITS-1:0] frameWord;

  ascpd_link_rx u_rx (
    .sclk     (sclk),
    .csN      (csN),
    .mosi     (mosi),
    .rxWord   (rxWord),
    .rxToggle (rxToggle)
  );

  // Pin and toggle synchronisers; edges are taken from the second stage.
  always_ff @(posedge mclk) begin
    if (srst) begin
      csSync1_reg  <= 1'b1;
      csSync2_reg  <= 1'b1;
      csPrev_reg   <= 1'b1;
      cnvSync1_reg <= 1'b1;
      cnvSync2_reg <= 1'b1;
      cnvPrev_reg  <= 1'b1;
    end else begin
      csSync1_reg  <= csN;
      csSync2_reg  <= csSync1_reg;
      csPrev_reg   <= csSync2_reg;
      cnvSync1_reg <= convertStartPinN;
      cnvSync2_reg <= cnvSync1_reg;
      cnvPrev_reg  <= cnvSync2_reg;
    end
  end

  // The completion flag is a level from the link domain; its rise marks a
  // new word. It is low whenever the select is high, so no reset is needed.
  always_ff @(posedge mclk) begin
    togSync1_reg <= rxToggle;
    togSync2_reg <= togSync1_reg;
    togSeen_reg  <= togSync2_reg;
  end

  assign csRise     = csSync2_reg & ~csPrev_reg;
  assign csFall     = ~csSync2_reg & csPrev_reg;
  assign cnvFall    = ~cnvSync2_reg & cnvPrev_reg;
  assign wordArrive = togSync2_reg & ~togSeen_reg;

  // A complete word waits here until its frame closes.
  always_ff @(posedge mclk) begin
    if (srst) begin
      heldWord_reg <= '0;
      pending_reg  <= 1'b0;
    end else begin
      if (wordArrive) begin
        heldWord_reg <= rxWord;
      end
      if (csRise) begin
        pending_reg <= 1'b0;
      end else if (wordArrive) begin
        pending_reg <= 1'b1;
      end
    end
  end

  // Decode at the select rise; a short frame never raises a word event.
  assign frameWord  = wordArrive ? rxWord : heldWord_reg;
  assign frameValid = csRise & (pending_reg | wordArrive);
  assign modeWord   = frameValid & ~frameWord[ROUTE_BIT];
  assign cfgWord    = frameValid &
                      (frameWord[SEL_MSB:SEL_LSB] == CFG_SELECT);
  assign nullWord   = ascpdIsNull(frameWord[SCAN_MSB:SCAN_LSB]);

  // Mode control register; null codes leave every field as it was.
  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_reg <= '{SCAN_RESET, CHAN_RESET, BIT_RESET, BIT_RESET, BIT_RESET};
    end else if (modeWord && !nullWord) begin
      mode_reg.scan               <= frameWord[SCAN_MSB:SCAN_LSB];
      mode_reg.startChannelPick   <= frameWord[CHAN_MSB:CHAN_LSB];
      mode_reg.autoPowerHi        <= frameWord[PM_HI_BIT];
      mode_reg.autoPowerLo        <= frameWord[PM_LO_BIT];
      mode_reg.softwareConvertBit <= frameWord[SOFTWARE_CONVERT_BIT_BIT];
    end
  end

  // Configuration register; power-down never touches it.
  always_ff @(posedge mclk) begin
    if (srst) begin
      cfg_reg <= '{BIT_RESET, BIT_RESET, FIELD2_RESET, FIELD2_RESET,
                   FIELD2_RESET};
    end else if (cfgWord) begin
      cfg_reg.referenceChoice  <= frameWord[REFERENCE_CHOICE_BIT];
      cfg_reg.averagingOn      <= frameWord[AVERAGING_ON_BIT];
      cfg_reg.averagingCount   <= frameWord[NAVG_MSB:NAVG_LSB];
      cfg_reg.scanCount        <= frameWord[NSCAN_MSB:NSCAN_LSB];
      cfg_reg.staticPowerField <= frameWord[SPM_MSB:SPM_LSB];
    end
  end

  // Automatic power-down events. The unused code 11 counts as normal.
  assign autoOn    = ({mode_reg.autoPowerHi, mode_reg.autoPowerLo}
                      == PM_FULL_OFF) ||
                     ({mode_reg.autoPowerHi, mode_reg.autoPowerLo}
                      == PM_BIAS_KEEP);
  assign convEnd   = internalClockMode ? conversionsDone : csRise;
  assign downEvent = autoOn & convEnd;
  assign wakeEvent = internalClockMode
                     ? (cnvFall | (modeWord & !nullWord &
                                   frameWord[SOFTWARE_CONVERT_BIT_BIT]))
                     : csFall;

  // A wake in the same cycle as a finish wins only while already powered down; otherwise the finish powers down.
  always_ff @(posedge mclk) begin
    if (srst) begin
      autoDown_reg <= 1'b0;
    end else if (autoDown_reg && wakeEvent) begin
      autoDown_reg <= 1'b0;
    end else if (downEvent) begin
      autoDown_reg <= 1'b1;
    end
  end

  // Results of the first two conversions after a wake are flagged unusable.
  always_ff @(posedge mclk) begin
    if (srst) begin
      discard_reg <= 2'h0;
    end else if (autoDown_reg && wakeEvent) begin
      discard_reg <= WAKE_DISCARD;
    end else if (convEnd && discard_reg != 2'h0) begin
      discard_reg <= discard_reg - 2'h1;
    end
  end

  // Static shutdown overrides automatic; standby keeps the bias alive.
  always_comb begin
    pwr_next = PWR_ON;
    if (cfg_reg.staticPowerField != SPM_OFF) begin
      pwr_next = (cfg_reg.staticPowerField == SPM_BIAS_KEEP)
                 ? PWR_BIAS_ONLY : PWR_FULL_OFF;
    end else if (autoDown_reg) begin
      pwr_next = mode_reg.autoPowerHi ? PWR_BIAS_ONLY
                                      : PWR_FULL_OFF;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pwr_reg   <= PWR_ON;
      taken_reg <= 1'b0;
    end else begin
      pwr_reg   <= pwr_next;
      taken_reg <= modeWord | cfgWord;
    end
  end

  // Decoded views of the held registers.
  assign modeReg                    = mode_reg;
  assign cfgReg                     = cfg_reg;
  assign startChannel               = mode_reg.startChannelPick;
  assign internalClockMode          = ascpdIsInternal(mode_reg.scan);
  assign arbitrarySequenceMode      = mode_reg.scan == SCAN_ARBITRARY;
  assign sequenceDepth              = 9'(SEQ_DEPTH);
  assign refExternalDiff            = cfg_reg.referenceChoice;
  assign negRefOnAnalogInputFifteen = ~cfg_reg.referenceChoice;
  assign averagingActive            = cfg_reg.averagingOn &
                                      internalClockMode &
                                      ~arbitrarySequenceMode;
  assign averageCount = averagingActive
                        ? 6'(AVG_BASE << cfg_reg.averagingCount)
                        : 6'h01;
  assign powerState                 = pwr_reg;
  assign discardResult              = discard_reg != 2'h0;
  assign commandTaken               = taken_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  null_keeps_mode_a: assert property (
    modeWord && nullWord |=> $stable(mode_reg))
    else $error("Null scan code changed the mode register.");

  chan_pick_a: assert property (
    modeWord && !nullWord |=>
      startChannel == $past(frameWord[CHAN_MSB:CHAN_LSB]))
    else $error("Channel pick not taken from the command word.");

  mode_route_a: assert property (
    modeWord |=> $stable(cfg_reg))
    else $error("Mode word altered the configuration.");

  cfg_route_a: assert property (
    cfgWord |=> refExternalDiff == $past(frameWord[REFERENCE_CHOICE_BIT]) &&
                cfg_reg.averagingOn == $past(frameWord[AVERAGING_ON_BIT]))
    else $error("Configuration word not stored.");

  cfg_select_a: assert property (
    frameValid && frameWord[ROUTE_BIT] &&
    frameWord[SEL_MSB:SEL_LSB] != CFG_SELECT |=> $stable(cfg_reg))
    else $error("Wrong select code reached the configuration.");

  avg_internal_a: assert property (
    averagingActive |-> cfg_reg.averagingOn &&
      mode_reg.scan inside {4'h2, 4'h3, 4'h5, 4'h7})
    else $error("Averaging active outside internal clock mode.");

  avg_count_a: assert property (
    averagingActive |-> averageCount ==
      ((cfg_reg.averagingCount == 2'h0) ? 6'h04 :
       (cfg_reg.averagingCount == 2'h1) ? 6'h08 :
       (cfg_reg.averagingCount == 2'h2) ? 6'h10 : 6'h20))
    else $error("Averaging count decoded wrongly.");

  static_off_a: assert property (
    cfg_reg.staticPowerField != SPM_OFF |=> powerState != PWR_ON)
    else $error("Static power field did not power down.");

  ext_down_a: assert property (
    csRise && autoOn && !internalClockMode && !autoDown_reg
      |=> autoDown_reg ##1 (cfg_reg.staticPowerField != SPM_OFF ||
                            powerState != PWR_ON))
    else $error("External clock auto power-down missed.");

  wake_discard_a: assert property (
    autoDown_reg && wakeEvent |=> !autoDown_reg && discard_reg == 2'h2)
    else $error("Wake did not arm the two-result discard.");

  frame_only_a: assert property (
    !$stable(cfg_reg) |-> $past(csRise))
    else $error("Configuration changed outside a frame close.");

  seq_cov_c:     cover property (modeWord && !nullWord &&
                   frameWord[SCAN_MSB:SCAN_LSB] == SCAN_ARBITRARY);
  standby_cov_c: cover property (powerState == PWR_BIAS_ONLY &&
                   autoDown_reg);
  cfg_cov_c:     cover property (cfgWord);
  discard_cov_c: cover property (discard_reg == 2'h1 ##[1:400]
                   discard_reg == 2'h0);

endmodule

// >>> verif/ascpd_host_model.sv
// Behavioural serial host that frames command words on the link.
`timescale 1ns/1ns
module ascpd_host_model (
  // Link pins driven by the host.
  output logic sclk,
  output logic csN,
  output logic mosi
);
  // Idle: deselected, clock parked low, data line driven high.
  // The select rises a little after time zero, so the receiver is already
  // listening and clears its count and flag on that edge.
  initial begin
    sclk = 1'b0;
    csN  = 1'b0;
    mosi = 1'b1;
    #1 csN = 1'b1;
  end

  // Select falls well before the first clock rise.
  task automatic frameOpen();
    csN = 1'b0;
    #21;
  endtask

  // Data moves while the clock is low, so every rise sees a settled bit.
  task automatic shiftBits(input logic [15:0] word, input int n);
    for (int i = 15; i > 15 - n; i--) begin
      mosi = word[i];
      #16 sclk = 1'b1;
      #16 sclk = 1'b0;
    end
  endtask

  // The clock stands still; the data line is driven to the inverse of its last bit.
  task automatic frameClose();
    #16 csN = 1'b1;
    mosi = ~mosi;
  endtask
endmodule

// >>> verif/tb_ascpd_core.sv
// Self-checking bench for the command decoder with a serial host model.
`timescale 1ns/1ns
module tb_ascpd_core;
  import ascpd_pkg::*;
  logic        mclk, srst, sclk, csN, mosi;
  logic        convertStartPinN, conversionsDone;
  ascpd_mode_t modeReg, curMode;
  ascpd_cfg_t  cfgReg, curCfg;
  logic [3:0]  startChannel;
  logic        arbitrarySequenceMode, internalClockMode, refExternalDiff;
  logic        negRefOnAnalogInputFifteen, averagingActive;
  logic        discardResult, commandTaken;
  logic [8:0]  sequenceDepth;
  logic [5:0]  averageCount;
  ascpd_pwr_t  powerState;
  logic [15:0] cnt;
  int          fail_count = 0;
  int          n_compared = 0;
  ascpd_pwr_t  autoExp[4] = '{PWR_ON, PWR_FULL_OFF, PWR_BIAS_ONLY, PWR_ON};

  ascpd_core #(.SEQ_DEPTH(SEQ_MAX)) ascpd_core_inst (
    .mclk(mclk), .srst(srst), .sclk(sclk), .csN(csN), .mosi(mosi),
    .convertStartPinN(convertStartPinN), .conversionsDone(conversionsDone),
    .modeReg(modeReg), .cfgReg(cfgReg), .startChannel(startChannel),
    .arbitrarySequenceMode(arbitrarySequenceMode),
    .sequenceDepth(sequenceDepth), .internalClockMode(internalClockMode),
    .refExternalDiff(refExternalDiff),
    .negRefOnAnalogInputFifteen(negRefOnAnalogInputFifteen),
    .averagingActive(averagingActive), .averageCount(averageCount),
    .powerState(powerState), .discardResult(discardResult),
    .commandTaken(commandTaken));

  ascpd_host_model ascpd_host_model_inst (
    .sclk(sclk), .csN(csN), .mosi(mosi));

  // System clock at 125 MHz.
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Mode word with bit 15 clear; unused bits left at zero.
  function automatic logic [15:0] mw(input logic [3:0] s, c,
                                     input logic [1:0] p, input logic w);
    return {1'b0, s, c, 2'h0, p, 1'b0, w, 1'b0};
  endfunction

  // Configuration word; the unused bits carry random junk.
  function automatic logic [15:0] cw(input ascpd_cfg_t c);
    return {CFG_SELECT, c[7:2], 1'($urandom), c[1:0], 2'($urandom)};
  endfunction

  // Power state that the static field alone should give.
  function automatic ascpd_pwr_t expPwr(input ascpd_cfg_t c);
    if (c.staticPowerField == 2'h0)
      return PWR_ON;
    return (c.staticPowerField == 2'h2) ? PWR_BIAS_ONLY : PWR_FULL_OFF;
  endfunction

  function automatic logic isInt(input logic [3:0] s);
    return s == 4'h2 || s == 4'h3 || s == 4'h5 || s == 4'h7;
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic summarize();
    if (fail_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic xfer(input logic [15:0] w, input int n);
    ascpd_host_model_inst.frameOpen();
    ascpd_host_model_inst.shiftBits(w, n);
    ascpd_host_model_inst.frameClose();
  endtask

  // A full word must be taken within a bounded number of cycles.
  task automatic send(input logic [15:0] w);
    xfer(w, 16);
    for (int i = 0; i < 20 && commandTaken !== 1'b1; i++)
      step(1);
    if (commandTaken !== 1'b1) begin
      chk("taken", 16'h1, 16'(commandTaken));
      summarize();
    end
    step(3);
  endtask

  task automatic pulseDone();
    conversionsDone = 1'b1;
    step(1);
    conversionsDone = 1'b0;
    step(3);
  endtask

  // Compare every decoded output except discardResult and commandTaken with what the written words imply.
  task automatic checkAll();
    logic a;
    logic [15:0] n;
    a = curCfg.averagingOn && isInt(curMode.scan) && curMode.scan != 4'h9;
    n = a ? 16'(6'h04 << curCfg.averagingCount) : 16'h1;
    chk("modeReg", 16'(curMode), 16'(modeReg));
    chk("cfgReg", 16'(curCfg), 16'(cfgReg));
    chk("chan", 16'(curMode.startChannelPick), 16'(startChannel));
    chk("arb", 16'(curMode.scan == 4'h9), 16'(arbitrarySequenceMode));
    chk("depth", 16'(SEQ_MAX), 16'(sequenceDepth));
    chk("intClk", 16'(isInt(curMode.scan)), 16'(internalClockMode));
    chk("refDiff", 16'(curCfg.referenceChoice), 16'(refExternalDiff));
    chk("neg15", 16'(!curCfg.referenceChoice),
        16'(negRefOnAnalogInputFifteen));
    chk("averaging_on", 16'(a), 16'(averagingActive));
    chk("avgCnt", n, 16'(averageCount));
    chk("power", 16'(expPwr(curCfg)), 16'(powerState));
  endtask

  // Main sequence.
  initial begin
    srst = 1'b1;
    convertStartPinN = 1'b1;
    conversionsDone = 1'b0;
    void'($urandom(96));
    curMode = '0;
    curCfg = '0;
    step(10);
    srst = 1'b0;
    step(6);
    checkAll();
    chk("discard0", 16'h0, 16'(discardResult));
    // Random mode and configuration words, corner values first.
    for (int k = 0; k < 16; k++) begin
      curMode = '{4'($urandom_range(9, 0)), 4'($urandom), 1'b0, 1'b0, 1'b0};
      curCfg = 8'($urandom);
      if (k == 0) begin
        curMode.scan = 4'h9;
        curMode.startChannelPick = 4'hf;
        curCfg = 8'hc0;
      end
      if (k == 1) begin
        curMode.scan = 4'h7;
        curCfg = 8'h78;
      end
      send(mw(curMode.scan, curMode.startChannelPick, 2'h0, 1'b0));
      send(cw(curCfg));
      checkAll();
    end
    // Codes 1010 to 1111 leave the mode register alone.
    for (int c = 10; c < 16; c++) begin
      send(mw(4'(c), 4'($urandom), 2'($urandom), 1'($urandom)));
      chk("nullMode", 16'(curMode), 16'(modeReg));
    end
    // A wrong select code and a short frame are both dropped.
    xfer({5'h11, 11'h7ff}, 16);
    step(12);
    chk("badSel", 16'(curCfg), 16'(cfgReg));
    cnt = 16'h0;
    xfer(mw(4'h3, 4'h5, 2'h1, 1'b0), 15);
    for (int i = 0; i < 12; i++) begin
      step(1);
      if (commandTaken === 1'b1)
        cnt++;
    end
    chk("shortTaken", 16'h0, cnt);
    chk("shortMode", 16'(curMode), 16'(modeReg));
    curCfg = '0;
    send(cw(curCfg));
    // Automatic power modes on the external clock.
    for (int p = 1; p < 4; p++) begin
      curMode = '{4'h4, 4'h3, p[1], p[0], 1'b0};
      send(mw(4'h4, 4'h3, 2'(p), 1'b0));
      send(mw(4'ha, 4'h0, 2'h0, 1'b0));
      chk("autoDown", 16'(autoExp[p]), 16'(powerState));
      ascpd_host_model_inst.frameOpen();
      step(6);
      chk("wake", 16'(PWR_ON), 16'(powerState));
      chk("discard", 16'(p < 3), 16'(discardResult));
      ascpd_host_model_inst.shiftBits(mw(4'hb, 4'h0, 2'h0, 1'b0), 16);
      ascpd_host_model_inst.frameClose();
      step(8);
      chk("keepMode", 16'(curMode), 16'(modeReg));
      chk("discard1", 16'(p < 3), 16'(discardResult));
      curMode = '{4'h4, 4'h3, 1'b0, 1'b0, 1'b0};
      send(mw(4'h4, 4'h3, 2'h0, 1'b0));
      send(mw(4'ha, 4'h0, 2'h0, 1'b0));
      send(mw(4'ha, 4'h0, 2'h0, 1'b0));
      chk("settled", 16'(PWR_ON), 16'(powerState));
      chk("discard2", 16'h0, 16'(discardResult));
    end
    // Internal clock: down on completion, up on the pin or the soft bit.
    curMode = '{4'h2, 4'h0, 1'b0, 1'b1, 1'b0};
    send(mw(4'h2, 4'h0, 2'h1, 1'b0));
    pulseDone();
    chk("intDown", 16'(PWR_FULL_OFF), 16'(powerState));
    convertStartPinN = 1'b0;
    step(6);
    chk("pinWake", 16'(PWR_ON), 16'(powerState));
    chk("pinDisc", 16'h1, 16'(discardResult));
    convertStartPinN = 1'b1;
    pulseDone();
    chk("intDown2", 16'(PWR_FULL_OFF), 16'(powerState));
    curMode.softwareConvertBit = 1'b1;
    send(mw(4'h2, 4'h0, 2'h1, 1'b1));
    chk("swWake", 16'(PWR_ON), 16'(powerState));
    chk("intMode", 16'(curMode), 16'(modeReg));
    summarize();
  end
endmodule
